/* cond_eval.sv */
`timescale 1ns/1ps
`default_nettype none
module cond_eval (
  dec_if.eval d
);
  logic [3:0] mask;
  logic [3:0] state;
  logic [3:0] live;
  logic [3:0] match;
  logic [1:0] tp;
  logic condition_field_hit;
  logic tp_hit;

  // Which of Z L V C really hold; Z and L derive accumulator relations
  assign mask = d.word[3:0];
  assign state = d.word[7:4];
  assign live = d.flags;
  assign match = mask & ~(state ^ live);
  assign tp = d.word[9:8];

  always_comb
  begin
    // Empty mask tests nothing; conditional calls then fall back to flag-condition select
    condition_field_hit = 1'b0;
    if (mask != 4'h0)
      condition_field_hit = |match; // [RULE25]
  end

  always_comb
  begin
    unique case (tp)
      opdec_pkg::TP_PIN_LOW: tp_hit = d.pin_low; // [RULE15]
      opdec_pkg::TP_TC_SET: tp_hit = d.test_ctrl; // [RULE15]
      opdec_pkg::TP_TC_CLEAR: tp_hit = ~d.test_ctrl; // [RULE15]
      default: tp_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    d.cond_known = 1'b1;
    if (d.word[15:8] == 8'h7B)
      d.cond_true = d.aux_nonzero; // [RULE11]
    else if (d.word[15:8] == 8'hE3)
      d.cond_true = condition_field_hit; // [RULE12] [RULE13] [RULE14]
    else if (d.word[15:12] == 4'hE && d.word[7:0] == 8'h00)
      d.cond_true = tp_hit;
    else if (d.word[15:10] == 6'b1110_10)
      d.cond_true = (mask == 4'h0) ? tp_hit : (condition_field_hit | tp_hit);
    else
    begin
      d.cond_true = 1'b0;
      d.cond_known = 1'b0;
    end
  end
endmodule : cond_eval
`default_nettype wire

/* dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dec_if;
  logic [15:0] word;
  logic [3:0] flags;
  logic test_ctrl;
  logic pin_low;
  logic aux_nonzero;
  logic cond_true;
  logic cond_known;
  modport eval (input word, input flags, input test_ctrl,
    input pin_low, input aux_nonzero, output cond_true, output cond_known);
  modport core (output word, output flags,
    output test_ctrl, output pin_low, output aux_nonzero, input cond_true, input cond_known);
endinterface : dec_if
`default_nettype wire

/* dsp_opcode_decoder_a_to_l.sv */
// How it works
// (RULE1) 0xBE00 decodes as accumulator absolute value, one cycle.
// (RULE2) Top nibble 0010: add with shift from bits 11-8, address low byte.
// (RULE3) High byte 0x61: add addressed word into upper accumulator half.
// (RULE4) High byte 0xB8: add unsigned 8-bit low-byte constant, one cycle.
// (RULE5) 0xBF9 plus shift nibble: two-word, two-cycle shifted long add.
// (RULE6) 0x60, 0x62, 0x63: add with carry, unsigned low, temp shift.
// (RULE7) High byte 0x78: add low-byte constant to current aux register.
// (RULE8) AND data 0x6E, AND long 0xBFB, AND shift16 0xBE81; constants two cycles.
// (RULE9) 0xBE04 adds product register into accumulator in one cycle.
// (RULE10) 0xBE20 branches to accumulator address, four cycles.
// (RULE11) High byte 0x7B branches if aux nonzero: four taken, two not.
// (RULE12) Under 0xE3: 0x8C ge, 0x04 gt, 0xCC le, 0x44 lt.
// (RULE13) Under 0xE3: 0x88 equal zero, 0x08 not equal zero.
// (RULE14) Under 0xE3: 0x11 carry, 0x01 no carry, 0x22 overflow, 0x02 none.
// (RULE15) 0xE1 test flag set, 0xE2 clear, 0xE0 pin low, three miss.
// (RULE16) Top nibble 0100 bit test by bits 11-8; 0x6F by temp register.
// (RULE17) Block moves 0xA8, 0xA9, 0xA5: two words, three cycles.
// (RULE18) Software never data-block-moves onto interrupt or allocation registers.
// (RULE19) 0xBE4x clears or sets status bits selected by low nibble; code strobes only the seven clear selectors, other codes give none.
// (RULE20) 0xBF4 with 01CM compares aux registers; 0xBE01 complements.
// (RULE21) High byte 0x77 copies data word to next higher address.
// (RULE22) High byte 0xAF reads port from second-word address, two cycles.
// (RULE23) Loads: nibble 0001 shifted, 0xBF8 long shifted, 0x6A high half.
// (RULE24) Conditional cycle count: middle figure taken, last figure not taken.
// (RULE25) Condition met when mask ANDed with state agreement leaves any bit.
`timescale 1ns/1ps
`default_nettype none
module dsp_opcode_decoder_a_to_l (
  input wire logic clk,
  input wire logic reset,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  output logic fetch_ready,
  input wire logic acc_zero,
  input wire logic acc_negative,
  input wire logic overflow_flag,
  input wire logic carry_flag,
  input wire logic test_control_flag,
  input wire logic aux_nonzero,
  input wire logic ext_pin,
  output opdec_pkg::op_t op_q,
  output logic op_valid_q,
  output logic [3:0] shift_field_q,
  output logic [7:0] operand_q,
  output logic [15:0] second_word_q,
  output logic two_words_q,
  output logic [2:0] cycles_q,
  output logic taken_q,
  output logic [6:0] clear_bits_q,
  output logic unknown_q
);
  typedef enum logic [2:0] {
    st_first_e = 3'b001,
    st_second_e = 3'b010,
    st_busy_e = 3'b100
  } state_t;

  state_t state_q;
  logic [15:0] first_q;
  logic [2:0] wait_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic take_first;
  logic take_second;
  logic [2:0] cycles_d;

  opdec_pkg::op_t op_first;
  logic two_first;
  logic [2:0] hit_first;
  logic [2:0] miss_first;
  logic [3:0] shift_first;
  logic [7:0] operand_first;

  dec_if dif ();

  // External pin is asynchronous to the core clock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= ext_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  opdec_cycles u_table (
    .word(state_q == st_first_e ? fetch_word : first_q),
    .op(op_first),
    .two_words(two_first),
    .cyc_hit(hit_first),
    .cyc_miss(miss_first),
    .shift_field(shift_first),
    .operand(operand_first)
  );

  assign dif.word = state_q == st_first_e ? fetch_word : first_q;
  assign dif.flags = {acc_zero, acc_negative, overflow_flag, carry_flag};
  assign dif.test_ctrl = test_control_flag;
  assign dif.pin_low = ~pin_sync_q; // [RULE15]
  assign dif.aux_nonzero = aux_nonzero;

  cond_eval u_cond (
    .d(dif)
  );

  assign take_first = state_q == st_first_e && fetch_valid && fetch_ready;
  assign take_second = state_q == st_second_e && fetch_valid && fetch_ready;
  // Conditions sampled when the operation completes decode
  assign cycles_d = (!dif.cond_known || dif.cond_true) ? hit_first : miss_first; // [RULE24]

  // Sequencer: take no fetch words during the extra cycles of long operations; fetch_ready stays high
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= st_first_e;
      first_q <= 16'h0000;
      wait_q <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        st_first_e:
        begin
          if (take_first)
          begin
            first_q <= fetch_word;
            if (two_first)
              state_q <= st_second_e; // [RULE5]
            else if (cycles_d > opdec_pkg::CYC_ONE)
            begin
              wait_q <= 3'(cycles_d - opdec_pkg::CYC_ONE - 3'h1);
              state_q <= st_busy_e; // [RULE10]
            end
          end
        end
        st_second_e:
        begin
          if (take_second)
          begin
            if (cycles_d > opdec_pkg::CYC_TWO)
            begin
              wait_q <= 3'(cycles_d - opdec_pkg::CYC_TWO - 3'h1);
              state_q <= st_busy_e; // [RULE17]
            end
            else
              state_q <= st_first_e; // [RULE22]
          end
        end
        st_busy_e:
        begin
          if (wait_q == 3'h0)
            state_q <= st_first_e;
          else
            wait_q <= wait_q - 3'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      fetch_ready <= 1'b0;
    else
      fetch_ready <= 1'b1;
  end

  // Decoded result, published as the last word is taken
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      op_q <= opdec_pkg::op_none_e;
      op_valid_q <= 1'b0;
      shift_field_q <= 4'h0;
      operand_q <= 8'h00;
      second_word_q <= 16'h0000;
      two_words_q <= 1'b0;
      cycles_q <= 3'h0;
      taken_q <= 1'b0;
      unknown_q <= 1'b0;
    end
    else
    begin
      op_valid_q <= (take_first && !two_first) || take_second;
      if ((take_first && !two_first) || take_second)
      begin
        op_q <= op_first; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE6] [RULE7]
        shift_field_q <= shift_first; // [RULE2] [RULE16] [RULE23]
        operand_q <= operand_first; // [RULE4] [RULE7] [RULE9] [RULE21]
        second_word_q <= take_second ? fetch_word : 16'h0000; // [RULE8] [RULE11] [RULE22]
        two_words_q <= take_second;
        cycles_q <= cycles_d; // [RULE11] [RULE24]
        taken_q <= dif.cond_known && dif.cond_true; // [RULE12] [RULE13] [RULE14] [RULE25]
        unknown_q <= op_first == opdec_pkg::op_none_e;
      end
    end
  end

  // One-hot strobe vector for status clears
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      clear_bits_q <= 7'h00;
    else if (take_first && op_first == opdec_pkg::op_status_clear_e)
    begin
      clear_bits_q <= '0;
      unique case (shift_first)
        opdec_pkg::CLR_BLOCK_DATA: clear_bits_q <= 7'h01; // [RULE19]
        opdec_pkg::CLR_INT_ENABLE: clear_bits_q <= 7'h02; // [RULE19]
        opdec_pkg::CLR_CARRY: clear_bits_q <= 7'h04; // [RULE19]
        opdec_pkg::CLR_OVF_MODE: clear_bits_q <= 7'h08; // [RULE19]
        opdec_pkg::CLR_SIGN_EXT: clear_bits_q <= 7'h10; // [RULE19]
        opdec_pkg::CLR_TEST_CTRL: clear_bits_q <= 7'h20; // [RULE19]
        opdec_pkg::CLR_EXT_FLAG: clear_bits_q <= 7'h40; // [RULE19]
        default: clear_bits_q <= 7'h00;
      endcase
    end
    else
      clear_bits_q <= 7'h00;
  end
endmodule : dsp_opcode_decoder_a_to_l
`default_nettype wire

/* fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  input wire logic clk,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [15:0] fetch_word
);
  initial
  begin
    fetch_valid = 1'b0;
    fetch_word = 16'h0000;
  end
  // Word held until an edge that accepts it
  task automatic offer(input logic [15:0] w, output bit ok);
    int n;
    ok = 1'b0;
    fetch_valid <= 1'b1;
    fetch_word <= w;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk);
      ok = (fetch_ready === 1'b1);
    end
  endtask : offer
  // Callers never aim block moves at interrupt or allocation registers
  task automatic send(input logic [15:0] w0, input logic [15:0] w1, input bit two,
    output bit ok);
    bit ok2;
    @(posedge clk);
    offer(w0, ok);
    if (two)
    begin
      offer(w1, ok2);
      ok = ok && ok2;
    end
    fetch_valid <= 1'b0;
    // Released bus must not keep showing the old word
    fetch_word <= ~fetch_word;
  endtask : send
endmodule : fetch_model
`default_nettype wire

/* opdec_cycles.sv */
`timescale 1ns/1ps
`default_nettype none
module opdec_cycles (
  input wire logic [15:0] word,
  output opdec_pkg::op_t op,
  output logic two_words,
  output logic [2:0] cyc_hit,
  output logic [2:0] cyc_miss,
  output logic [3:0] shift_field,
  output logic [7:0] operand
);
  always_comb
  begin
    op = opdec_pkg::op_none_e;
    two_words = 1'b0;
    cyc_hit = opdec_pkg::CYC_ONE;
    cyc_miss = opdec_pkg::CYC_ONE;
    shift_field = word[11:8];
    operand = word[7:0];
    if (word == 16'hBE00)
      op = opdec_pkg::op_abs_e; // [RULE1]
    else if (word == 16'hBE01)
      op = opdec_pkg::op_complement_e; // [RULE20]
    else if (word == 16'hBE04)
      op = opdec_pkg::op_add_product_e; // [RULE9]
    else if (word == 16'hBE20)
    begin
      op = opdec_pkg::op_branch_acc_e; // [RULE10]
      cyc_hit = opdec_pkg::CYC_FOUR;
      cyc_miss = opdec_pkg::CYC_FOUR;
    end
    else if (word == 16'hBE22)
      op = opdec_pkg::op_idle_e;
    else if (word == 16'hBE30)
    begin
      op = opdec_pkg::op_call_ind_e;
      cyc_hit = opdec_pkg::CYC_FOUR;
      cyc_miss = opdec_pkg::CYC_FOUR;
    end
    else if (word[15:4] == 12'hBE4)
    begin
      op = opdec_pkg::op_status_clear_e; // [RULE19]
      shift_field = word[3:0];
    end
    else if (word[15:5] == 11'b1011_1110_011)
    begin
      op = opdec_pkg::op_soft_int_e;
      operand = {3'h0, word[4:0]};
      cyc_hit = opdec_pkg::CYC_FOUR;
      cyc_miss = opdec_pkg::CYC_FOUR;
    end
    else if (word == 16'hBE81)
    begin
      op = opdec_pkg::op_and_16_e; // [RULE8]
      two_words = 1'b1;
      cyc_hit = opdec_pkg::CYC_TWO;
      cyc_miss = opdec_pkg::CYC_TWO;
    end
    else if (word[15:2] == 14'b1011_1111_0100_01)
    begin
      op = opdec_pkg::op_aux_compare_e; // [RULE20]
      operand = {6'h00, word[1:0]};
    end
    else if (word[15:4] == 12'hBF9 || word[15:4] == 12'hBFB || word[15:4] == 12'hBF8)
    begin
      if (word[7:4] == 4'h9)
        op = opdec_pkg::op_add_long_e; // [RULE5]
      else if (word[7:4] == 4'hB)
        op = opdec_pkg::op_and_long_e; // [RULE8]
      else
        op = opdec_pkg::op_load_long_e; // [RULE23]
      shift_field = word[3:0];
      two_words = 1'b1;
      cyc_hit = opdec_pkg::CYC_TWO;
      cyc_miss = opdec_pkg::CYC_TWO;
    end
    else
    begin
      unique case (word[15:12])
        4'h2: op = opdec_pkg::op_add_shift_e; // [RULE2]
        4'h1: op = opdec_pkg::op_load_shift_e; // [RULE23]
        4'h4: op = opdec_pkg::op_bit_test_e; // [RULE16]
        4'hE:
        begin
          two_words = 1'b1;
          cyc_hit = opdec_pkg::CYC_FOUR;
          cyc_miss = opdec_pkg::CYC_TWO; // [RULE24]
          if (word[11:10] == 2'b10)
            op = opdec_pkg::op_cond_call_e;
          else if (word[11:8] <= 4'h3)
          begin
            op = opdec_pkg::op_cond_branch_e; // [RULE12]
            if (word[11:8] == 4'h0)
              cyc_miss = opdec_pkg::CYC_THREE; // [RULE15]
          end
          else
          begin
            two_words = 1'b0;
            cyc_hit = opdec_pkg::CYC_ONE;
            cyc_miss = opdec_pkg::CYC_ONE;
          end
        end
        default:
        begin
          unique case (word[15:8])
            8'h61: op = opdec_pkg::op_add_high_e; // [RULE3]
            8'hB8: op = opdec_pkg::op_add_short_e; // [RULE4]
            8'h60: op = opdec_pkg::op_add_carry_e; // [RULE6]
            8'h62: op = opdec_pkg::op_add_unsigned_e; // [RULE6]
            8'h63: op = opdec_pkg::op_add_temp_e; // [RULE6]
            8'h78: op = opdec_pkg::op_aux_add_e; // [RULE7]
            8'h6E: op = opdec_pkg::op_and_data_e; // [RULE8]
            8'h6F: op = opdec_pkg::op_bit_test_idx_e; // [RULE16]
            8'h77: op = opdec_pkg::op_data_move_e; // [RULE21]
            8'h6A: op = opdec_pkg::op_load_high_e; // [RULE23]
            8'h79, 8'h7A, 8'h7B:
            begin
              two_words = 1'b1;
              cyc_hit = opdec_pkg::CYC_FOUR;
              cyc_miss = (word[15:8] == 8'h7B) ? opdec_pkg::CYC_TWO
                : opdec_pkg::CYC_FOUR; // [RULE11]
              op = (word[15:8] == 8'h79) ? opdec_pkg::op_branch_e
                : (word[15:8] == 8'h7A) ? opdec_pkg::op_call_e
                : opdec_pkg::op_branch_aux_e; // [RULE11]
            end
            8'hA8, 8'hA9, 8'hA5:
            begin
              two_words = 1'b1;
              cyc_hit = opdec_pkg::CYC_THREE; // [RULE17]
              cyc_miss = opdec_pkg::CYC_THREE;
              op = (word[15:8] == 8'hA8) ? opdec_pkg::op_move_src_e
                : (word[15:8] == 8'hA9) ? opdec_pkg::op_move_dst_e
                : opdec_pkg::op_move_prog_e; // [RULE17]
            end
            8'hAF:
            begin
              op = opdec_pkg::op_port_in_e; // [RULE22]
              two_words = 1'b1;
              cyc_hit = opdec_pkg::CYC_TWO;
              cyc_miss = opdec_pkg::CYC_TWO;
            end
            default: op = opdec_pkg::op_none_e;
          endcase
        end
      endcase
    end
  end
endmodule : opdec_cycles
`default_nettype wire

/* opdec_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module opdec_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic fetch_ready,
  input wire logic acc_zero,
  input wire logic acc_negative,
  input wire logic overflow_flag,
  input wire logic carry_flag,
  input wire logic test_control_flag,
  input wire logic aux_nonzero,
  input wire logic ext_pin,
  input wire opdec_pkg::op_t op_q,
  input wire logic op_valid_q,
  input wire logic [3:0] shift_field_q,
  input wire logic [7:0] operand_q,
  input wire logic [15:0] second_word_q,
  input wire logic two_words_q,
  input wire logic [2:0] cycles_q,
  input wire logic taken_q,
  input wire logic [6:0] clear_bits_q,
  input wire logic unknown_q
);
  logic [15:0] last_word_q;
  logic take_q;
  // Last offered word; the answer lands one cycle after the final take
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      last_word_q <= 16'h0000;
      take_q <= 1'b0;
    end
    else
    begin
      last_word_q <= fetch_word;
      take_q <= fetch_valid && fetch_ready;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_abs_one_cycle: assert property (op_valid_q && op_q == opdec_pkg::op_abs_e
    |-> cycles_q == 3'h1 && !two_words_q) else $error("abs timing wrong");
  chk_add_shift_fields: assert property (op_valid_q && op_q == opdec_pkg::op_add_shift_e
    |-> last_word_q[15:12] == 4'h2 && shift_field_q == last_word_q[11:8]
    && operand_q == last_word_q[7:0]) else $error("add fields wrong");
  chk_long_add_words: assert property (op_valid_q && op_q == opdec_pkg::op_add_long_e
    |-> two_words_q && cycles_q == 3'h2) else $error("long add timing wrong");
  chk_second_word_kept: assert property (op_valid_q && two_words_q
    |-> take_q && second_word_q == last_word_q) else $error("second word wrong");
  chk_acc_branch_cycles: assert property (op_valid_q && op_q == opdec_pkg::op_branch_acc_e
    |-> cycles_q == 3'h4 && !two_words_q) else $error("acc branch cycles wrong");
  chk_aux_branch_cycles: assert property (op_valid_q && op_q == opdec_pkg::op_branch_aux_e
    |-> cycles_q == (taken_q ? 3'h4 : 3'h2)) else $error("aux branch cycles wrong");
  chk_block_move_timing: assert property (op_valid_q && (op_q == opdec_pkg::op_move_src_e
    || op_q == opdec_pkg::op_move_dst_e || op_q == opdec_pkg::op_move_prog_e)
    |-> two_words_q && cycles_q == 3'h3) else $error("block move timing wrong");
  chk_clear_one_hot: assert property (clear_bits_q != 7'h00
    |-> op_valid_q && op_q == opdec_pkg::op_status_clear_e && $onehot(clear_bits_q))
    else $error("clear pulse wrong");
endmodule : opdec_monitor
`default_nettype wire

/* opdec_pkg.sv */
package opdec_pkg;
  // Operation classes
  typedef enum logic [5:0] {
    op_none_e = 6'h00,
    op_abs_e = 6'h01,
    op_add_shift_e = 6'h02,
    op_add_high_e = 6'h03,
    op_add_short_e = 6'h04,
    op_add_long_e = 6'h05,
    op_add_carry_e = 6'h06,
    op_add_unsigned_e = 6'h07,
    op_add_temp_e = 6'h08,
    op_aux_add_e = 6'h09,
    op_and_data_e = 6'h0A,
    op_and_long_e = 6'h0B,
    op_and_16_e = 6'h0C,
    op_add_product_e = 6'h0D,
    op_branch_e = 6'h0E,
    op_branch_acc_e = 6'h0F,
    op_branch_aux_e = 6'h10,
    op_cond_branch_e = 6'h11,
    op_bit_test_e = 6'h12,
    op_bit_test_idx_e = 6'h13,
    op_move_src_e = 6'h14,
    op_move_dst_e = 6'h15,
    op_move_prog_e = 6'h16,
    op_call_ind_e = 6'h17,
    op_call_e = 6'h18,
    op_cond_call_e = 6'h19,
    op_status_clear_e = 6'h1A,
    op_complement_e = 6'h1B,
    op_aux_compare_e = 6'h1C,
    op_data_move_e = 6'h1D,
    op_idle_e = 6'h1E,
    op_port_in_e = 6'h1F,
    op_soft_int_e = 6'h20,
    op_load_shift_e = 6'h21,
    op_load_long_e = 6'h22,
    op_load_high_e = 6'h23
  } op_t;

  // Status-clear selectors (low nibble of the status pattern)
  localparam logic [3:0] CLR_BLOCK_DATA = 4'h4;
  localparam logic [3:0] CLR_INT_ENABLE = 4'h0;
  localparam logic [3:0] CLR_CARRY = 4'hE;
  localparam logic [3:0] CLR_OVF_MODE = 4'h2;
  localparam logic [3:0] CLR_SIGN_EXT = 4'h6;
  localparam logic [3:0] CLR_TEST_CTRL = 4'hA;
  localparam logic [3:0] CLR_EXT_FLAG = 4'hC;

  // Condition field bit positions (Z L V C)
  localparam int COND_Z = 3;
  localparam int COND_L = 2;
  localparam int COND_V = 1;
  localparam int COND_C = 0;

  // Flag-condition select codes
  localparam logic [1:0] TP_PIN_LOW = 2'h0;
  localparam logic [1:0] TP_TC_SET = 2'h1;
  localparam logic [1:0] TP_TC_CLEAR = 2'h2;

  // Cycle figures
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
endpackage : opdec_pkg

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic acc_zero = 1'b0, acc_negative = 1'b0, overflow_flag = 1'b0, carry_flag = 1'b0;
  logic test_control_flag = 1'b0, aux_nonzero = 1'b0, ext_pin = 1'b1;
  logic fetch_valid, fetch_ready, op_valid_q, two_words_q, taken_q, unknown_q;
  logic [15:0] fetch_word, second_word_q;
  logic [3:0] shift_field_q;
  logic [7:0] operand_q;
  logic [2:0] cycles_q;
  logic [6:0] clear_bits_q;
  opdec_pkg::op_t op_q;
  int mismatches = 0;
  int n_checks = 0;
  localparam logic [15:0] ONE_W [20] = '{16'hBE00, 16'h2A55, 16'h6112, 16'hB8FF, 16'h6001,
    16'h6202, 16'h6303, 16'h7880, 16'h6E10, 16'hBE04, 16'hBE20, 16'h4C33, 16'h6F44, 16'hBE01,
    16'hBF45, 16'h7777, 16'h1F22, 16'h6A66, 16'hBE22, 16'hBE30};
  localparam logic [5:0] ONE_OP [20] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h07, 6'h08, 6'h09,
    6'h0A, 6'h0D, 6'h0F, 6'h12, 6'h13, 6'h1B, 6'h1C, 6'h1D, 6'h21, 6'h23, 6'h1E, 6'h17};
  localparam logic [15:0] TW_A [10] = '{16'hBF93, 16'hBFB5, 16'hBE81, 16'hA810, 16'hA920,
    16'hA530, 16'hAF40, 16'hBF87, 16'h7910, 16'h7A20};
  localparam logic [5:0] TW_OP [10] = '{6'h05, 6'h0B, 6'h0C, 6'h14, 6'h15, 6'h16, 6'h1F, 6'h22,
    6'h0E, 6'h18};
  localparam logic [2:0] TW_CY [10] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2, 3'h4,
    3'h4};
  localparam logic [7:0] CODES [10] = '{8'h8C, 8'h04, 8'hCC, 8'h44, 8'h88, 8'h08, 8'h11, 8'h01,
    8'h22, 8'h02};
  localparam logic [3:0] CLR [7] = '{opdec_pkg::CLR_BLOCK_DATA, opdec_pkg::CLR_INT_ENABLE,
    opdec_pkg::CLR_CARRY, opdec_pkg::CLR_OVF_MODE, opdec_pkg::CLR_SIGN_EXT,
    opdec_pkg::CLR_TEST_CTRL, opdec_pkg::CLR_EXT_FLAG};
  always #10 clk = ~clk;
  dsp_opcode_decoder_a_to_l u_dsp_opcode_decoder_a_to_l (.clk(clk), .reset(reset),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_ready(fetch_ready),
    .acc_zero(acc_zero), .acc_negative(acc_negative), .overflow_flag(overflow_flag),
    .carry_flag(carry_flag), .test_control_flag(test_control_flag),
    .aux_nonzero(aux_nonzero), .ext_pin(ext_pin), .op_q(op_q), .op_valid_q(op_valid_q),
    .shift_field_q(shift_field_q), .operand_q(operand_q), .second_word_q(second_word_q),
    .two_words_q(two_words_q), .cycles_q(cycles_q), .taken_q(taken_q),
    .clear_bits_q(clear_bits_q), .unknown_q(unknown_q));
  fetch_model u_fetch_model (.clk(clk), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Idle gap first covers the busy cycles of the previous instruction
  task automatic run(input logic [15:0] w0, input logic [15:0] w1, input bit two);
    bit ok;
    int n;
    repeat (4) @(posedge clk);
    u_fetch_model.send(w0, w1, two, ok);
    chk("taken", 16'h0001, {15'h0, ok});
    // Result launches on the edge that took the last word
    #1;
    for (n = 0; n < 8 && op_valid_q !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk("op_valid_q", 16'h0001, {15'h0, op_valid_q});
    if (op_valid_q !== 1'b1)
      test_done();
  endtask : run
  task automatic chk_op(input logic [5:0] op, input logic [2:0] cy, input logic two);
    chk("op_q", {10'h0, op}, {10'h0, op_q});
    chk("cycles_q", {13'h0, cy}, {13'h0, cycles_q});
    chk("two_words_q", {15'h0, two}, {15'h0, two_words_q});
    chk("unknown_q", 16'h0000, {15'h0, unknown_q});
  endtask : chk_op
  task automatic t_one_word;
    for (int i = 0; i < 20; i++)
    begin
      run(ONE_W[i], 16'h0000, 1'b0);
      chk_op(ONE_OP[i], ONE_W[i] inside {16'hBE20, 16'hBE30} ? 3'h4 : 3'h1,
        1'b0);
    end
  endtask : t_one_word
  task automatic t_two_word;
    for (int i = 0; i < 10; i++)
    begin
      run(TW_A[i], 16'h0300 + 16'(i), 1'b1);
      chk_op(TW_OP[i], TW_CY[i], 1'b1);
      chk("second_word_q", 16'h0300 + 16'(i), second_word_q);
    end
  endtask : t_two_word
  task automatic t_cond;
    logic exp;
    for (int i = 0; i < 10; i++)
      for (int f = 0; f < 16; f++)
      begin
        // Zero accumulator is left out for the positive test, where readings differ
        if (CODES[i] == 8'h04 && f[3])
          continue;
        @(posedge clk);
        {acc_zero, acc_negative, overflow_flag, carry_flag} <= 4'(f);
        exp = |(CODES[i][3:0] & ~(CODES[i][7:4] ^ 4'(f)));
        run({8'hE3, CODES[i]}, 16'h2000, 1'b1);
        chk("taken_q", {15'h0, exp}, {15'h0, taken_q});
        chk_op(6'h11, exp ? 3'h4 : 3'h2, 1'b1);
      end
  endtask : t_cond
  task automatic t_flag;
    logic [1:0] k;
    logic v;
    logic exp;
    for (int i = 0; i < 8; i++)
    begin
      k = 2'(i / 2);
      v = i[0];
      @(posedge clk);
      test_control_flag <= v;
      ext_pin <= v;
      aux_nonzero <= v;
      exp = (k == 2'h0 || k == 2'h3) ? v : !v;
      run(k == 2'h0 ? 16'hE100 : k == 2'h1 ? 16'hE200 : k == 2'h2 ? 16'hE000 : 16'h7B10,
        16'h1234, 1'b1);
      chk("taken_q", {15'h0, exp}, {15'h0, taken_q});
      chk_op(k == 2'h3 ? 6'h10 : 6'h11, exp ? 3'h4 : (k == 2'h2 ? 3'h3 : 3'h2), 1'b1);
    end
  endtask : t_flag
  task automatic t_status;
    for (int i = 0; i < 7; i++)
    begin
      run({12'hBE4, CLR[i]}, 16'h0000, 1'b0);
      chk("clear_bits_q", {9'h0, 7'h01 << i}, {9'h0, clear_bits_q});
      chk_op(6'h1A, 3'h1, 1'b0);
    end
  endtask : t_status
  task automatic t_unknown;
    bit ok;
    repeat (4) @(posedge clk);
    u_fetch_model.send(16'hBE52, 16'h0000, 1'b0, ok);
    @(posedge clk);
    #1;
    chk("unknown_q", 16'h0001, {15'h0, unknown_q});
  endtask : t_unknown
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    chk("fetch_ready", 16'h0000, {15'h0, fetch_ready});
    chk("op_valid_q", 16'h0000, {15'h0, op_valid_q});
    @(posedge clk);
    reset <= 1'b0;
    t_one_word();
    t_one_word();
    t_two_word();
    t_cond();
    t_flag();
    t_status();
    t_unknown();
    test_done();
  end
endmodule : tb_top
bind dsp_opcode_decoder_a_to_l opdec_monitor u_opdec_monitor (.clk(clk), .reset(reset),
  .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_ready(fetch_ready),
  .acc_zero(acc_zero), .acc_negative(acc_negative), .overflow_flag(overflow_flag),
  .carry_flag(carry_flag), .test_control_flag(test_control_flag), .aux_nonzero(aux_nonzero),
  .ext_pin(ext_pin), .op_q(op_q), .op_valid_q(op_valid_q), .shift_field_q(shift_field_q),
  .operand_q(operand_q), .second_word_q(second_word_q), .two_words_q(two_words_q),
  .cycles_q(cycles_q), .taken_q(taken_q), .clear_bits_q(clear_bits_q), .unknown_q(unknown_q));
`default_nettype wire
